// ### idil_top.sv
// digital i/o and interrupt logic of the add-in card
// assumes one host i/o access at a time, inputs synchronous to CLK
//
// How it works
// - plain outputs go low at power-up and stay low while board reset is low
// - plain inputs read as disabled until board reset control is high
// - isolated outputs clear to off at power-up and while board reset is low
// - isolated output readback gives 1 for on and 0 for off
// - isolated inputs read 0 when energised and 1 when off
// - two interrupt channels, sourced from input bits zero and one
// - host request is a level, active low, repeating while held low
// - channels rest low, a high pulse requests; software restores low level
// - equal priority; simultaneous channels give one request, status shows both
// - first channel enable bit: 0 disables, 1 enables
// - first channel polarity: 0 inverts bit zero, 1 passes it true
// - second channel enable bit: 0 disables, 1 enables
// - second channel polarity: 0 inverts bit one, 1 passes it true
// - status register shows present level of each channel source
// - polarity writes act at once on the channel
module idil_top
    import idil_pkg::*;
#(
    parameter int DIO_WIDTH = 16
) (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // host i/o port
    input wire idil_io_req_t IO_REQ,
    output logic [7:0] IO_RDATA,
    output logic IO_RVALID,
    // non-isolated pins
    input wire logic [DIO_WIDTH-1:0] PLAIN_IN,
    output logic PLAIN_IN_ENABLE,
    output logic [DIO_WIDTH-1:0] PLAIN_OUT,
    // isolated pins
    input wire logic [DIO_WIDTH-1:0] ISO_IN,
    output logic [DIO_WIDTH-1:0] ISO_OUT,
    // host interrupt request
    output logic IRQ_N
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic board_run;
    logic [IDIL_IRQ_CHANNELS-1:0] irq_enable;
    logic [IDIL_IRQ_CHANNELS-1:0] irq_polarity;
    logic [DIO_WIDTH-1:0] plain_in_q;
    logic [DIO_WIDTH-1:0] iso_in_q;
    logic [IDIL_IRQ_CHANNELS-1:0] irq_source;
    logic [IDIL_IRQ_CHANNELS-1:0] irq_channel;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire wr_reset = IO_REQ.wr && (IO_REQ.addr == IDIL_OFS_BOARD_RESET);
    wire wr_enable = IO_REQ.wr && (IO_REQ.addr == IDIL_OFS_IRQ_ENABLE);
    wire wr_polarity = IO_REQ.wr && (IO_REQ.addr == IDIL_OFS_IRQ_POLARITY_SELECT);
    wire wr_plain_lo = IO_REQ.wr && (IO_REQ.addr == IDIL_OFS_PLAIN_OUT_LO);
    wire wr_plain_hi = IO_REQ.wr && (IO_REQ.addr == IDIL_OFS_PLAIN_OUT_HI);
    wire wr_iso_lo = IO_REQ.wr && (IO_REQ.addr == IDIL_OFS_ISO_OUT_LO);
    wire wr_iso_hi = IO_REQ.wr && (IO_REQ.addr == IDIL_OFS_ISO_OUT_HI);

    // disabled plain port reads as zero, never stale pin data
    wire [DIO_WIDTH-1:0] plain_in_view = board_run ? plain_in_q : '0;
    // opto stage inverts: energised input reads 0
    wire [DIO_WIDTH-1:0] iso_in_view = ~iso_in_q;

    wire [7:0] status_view = {6'h00, irq_source};

    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = IDIL_READ_UNMAPPED;
        if (IO_REQ.addr == IDIL_OFS_BOARD_RESET) begin
            next_rdata = {7'h00, board_run};
        end else if (IO_REQ.addr == IDIL_OFS_IRQ_ENABLE) begin
            next_rdata = {6'h00, irq_enable};
        end else if (IO_REQ.addr == IDIL_OFS_IRQ_SOURCE_STATUS) begin
            next_rdata = status_view;
        end else if (IO_REQ.addr == IDIL_OFS_IRQ_POLARITY_SELECT) begin
            next_rdata = {6'h00, irq_polarity};
        end else if (IO_REQ.addr == IDIL_OFS_PLAIN_OUT_LO) begin
            next_rdata = PLAIN_OUT[7:0];
        end else if (IO_REQ.addr == IDIL_OFS_PLAIN_OUT_HI) begin
            next_rdata = PLAIN_OUT[15:8];
        end else if (IO_REQ.addr == IDIL_OFS_PLAIN_IN_LO) begin
            next_rdata = plain_in_view[7:0];
        end else if (IO_REQ.addr == IDIL_OFS_PLAIN_IN_HI) begin
            next_rdata = plain_in_view[15:8];
        end else if (IO_REQ.addr == IDIL_OFS_ISO_OUT_LO) begin
            next_rdata = ISO_OUT[7:0];
        end else if (IO_REQ.addr == IDIL_OFS_ISO_OUT_HI) begin
            next_rdata = ISO_OUT[15:8];
        end else if (IO_REQ.addr == IDIL_OFS_ISO_IN_LO) begin
            next_rdata = iso_in_view[7:0];
        end else if (IO_REQ.addr == IDIL_OFS_ISO_IN_HI) begin
            next_rdata = iso_in_view[15:8];
        end
    end

    // ----------------------------------------------------------------
    // interrupt channels
    // ----------------------------------------------------------------
    // sources are plain input bits zero and one, taken before the port gate
    assign irq_source = plain_in_q[IDIL_IRQ_CHANNELS-1:0];

    genvar ch;
    generate
        for (ch = 0; ch < IDIL_IRQ_CHANNELS; ch++) begin : g_chan
            // polarity 1 passes the level, 0 inverts it; acts without delay
            wire adjusted = irq_polarity[ch] ? irq_source[ch] : ~irq_source[ch];
            // disabled channel rests low, so it can never hold the request
            assign irq_channel[ch] = adjusted & irq_enable[ch];
        end
    endgenerate

    // one shared line: two channels high together give a single request
    wire next_irq_n = ~(|irq_channel);

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            board_run <= IDIL_RST_BOARD_RESET[IDIL_BIT_BOARD_RUN];
            irq_enable <= IDIL_RST_IRQ_ENABLE[IDIL_IRQ_CHANNELS-1:0];
            irq_polarity <= IDIL_RST_IRQ_POLARITY[IDIL_IRQ_CHANNELS-1:0];
        end else begin
            if (wr_reset) begin
                board_run <= IO_REQ.wdata[IDIL_BIT_BOARD_RUN];
            end
            if (wr_enable) begin
                irq_enable <= IO_REQ.wdata[IDIL_IRQ_CHANNELS-1:0];
            end
            if (wr_polarity) begin
                irq_polarity <= IO_REQ.wdata[IDIL_IRQ_CHANNELS-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // low board reset overrides writes, so outputs cannot glitch on
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PLAIN_OUT <= '0;
            ISO_OUT <= '0;
        end else if (!board_run) begin
            PLAIN_OUT <= '0;
            ISO_OUT <= '0;
        end else begin
            if (wr_plain_lo) begin
                PLAIN_OUT[7:0] <= IO_REQ.wdata;
            end
            if (wr_plain_hi) begin
                PLAIN_OUT[15:8] <= IO_REQ.wdata;
            end
            if (wr_iso_lo) begin
                ISO_OUT[7:0] <= IO_REQ.wdata;
            end
            if (wr_iso_hi) begin
                ISO_OUT[15:8] <= IO_REQ.wdata;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            plain_in_q <= '0;
            iso_in_q <= '0;
            PLAIN_IN_ENABLE <= 1'b0;
            IRQ_N <= 1'b1;
            IO_RDATA <= IDIL_READ_UNMAPPED;
            IO_RVALID <= 1'b0;
        end else begin
            plain_in_q <= PLAIN_IN;
            iso_in_q <= ISO_IN;
            PLAIN_IN_ENABLE <= board_run;
            IRQ_N <= next_irq_n;
            IO_RVALID <= IO_REQ.rd;
            if (IO_REQ.rd) begin
                IO_RDATA <= next_rdata;
            end
        end
    end

endmodule

// ### idil_pkg.sv
// constants and types for the digital i/o and interrupt logic
// assumes an 8-bit host i/o port decoded down to one byte of address
package idil_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] IDIL_OFS_BOARD_RESET = 8'h00;
    localparam logic [7:0] IDIL_OFS_IRQ_ENABLE = 8'h05;
    localparam logic [7:0] IDIL_OFS_IRQ_SOURCE_STATUS = 8'h07;
    localparam logic [7:0] IDIL_OFS_PLAIN_OUT_LO = 8'h10;
    localparam logic [7:0] IDIL_OFS_PLAIN_OUT_HI = 8'h11;
    localparam logic [7:0] IDIL_OFS_PLAIN_IN_LO = 8'h12;
    localparam logic [7:0] IDIL_OFS_PLAIN_IN_HI = 8'h13;
    localparam logic [7:0] IDIL_OFS_ISO_OUT_LO = 8'h14;
    localparam logic [7:0] IDIL_OFS_ISO_OUT_HI = 8'h15;
    localparam logic [7:0] IDIL_OFS_ISO_IN_LO = 8'h16;
    localparam logic [7:0] IDIL_OFS_ISO_IN_HI = 8'h17;
    localparam logic [7:0] IDIL_OFS_IRQ_POLARITY_SELECT = 8'h2a;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int IDIL_BIT_BOARD_RUN = 0;
    localparam int IDIL_IRQ_CHANNELS = 2;
    localparam logic [7:0] IDIL_RST_BOARD_RESET = 8'h00;
    localparam logic [7:0] IDIL_RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] IDIL_RST_IRQ_POLARITY = 8'h00;
    localparam logic [7:0] IDIL_READ_UNMAPPED = 8'h00;

    // ----------------------------------------------------------------
    // host i/o request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } idil_io_req_t;

endpackage

// ### idil_checker.sv
// concurrent checks on the i/o and interrupt block ports
// assumes idil_pkg compiled first; bound to idil_top below
module idil_checker
    import idil_pkg::*;
#(
    parameter int DIO_WIDTH = 16
) (
    // clock, reset, host port
    input wire logic CLK, input wire logic ARST_N, input wire idil_io_req_t IO_REQ,
    input wire logic [7:0] IO_RDATA, input wire logic IO_RVALID,
    // pins and request
    input wire logic [DIO_WIDTH-1:0] PLAIN_IN, input wire logic PLAIN_IN_ENABLE,
    input wire logic [DIO_WIDTH-1:0] PLAIN_OUT, input wire logic [DIO_WIDTH-1:0] ISO_IN,
    input wire logic [DIO_WIDTH-1:0] ISO_OUT, input wire logic IRQ_N
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    sequence status_rd;
        IO_REQ.rd && IO_REQ.addr == IDIL_OFS_IRQ_SOURCE_STATUS;
    endsequence
    sequence iso_wr;
        IO_REQ.wr && IO_REQ.addr == IDIL_OFS_ISO_OUT_LO && PLAIN_IN_ENABLE &&
        !$past(IO_REQ.wr && IO_REQ.addr == IDIL_OFS_BOARD_RESET);
    endsequence
    outs_cleared_a: assert property (!PLAIN_IN_ENABLE && !$past(PLAIN_IN_ENABLE) |->
        PLAIN_OUT == '0 && ISO_OUT == '0) else $error("outputs not cleared");
    rvalid_pulse_a: assert property (IO_RVALID == $past(IO_REQ.rd))
        else $error("read answer late");
    status_read_a: assert property (status_rd |=> IO_RDATA == {6'h00, $past(PLAIN_IN[1:0], 2)})
        else $error("status wrong");
    plain_off_a: assert property (IO_RVALID && !PLAIN_IN_ENABLE &&
        $past(IO_REQ.addr) == IDIL_OFS_PLAIN_IN_LO |-> IO_RDATA == 8'h00) else $error("input leaks");
    unmapped_zero_a: assert property (IO_RVALID && $past(IO_REQ.addr) == 8'h3f |->
        IO_RDATA == IDIL_READ_UNMAPPED) else $error("unmapped read nonzero");
    rdata_hold_a: assert property (!IO_RVALID |-> $stable(IO_RDATA)) else $error("rdata moved");
    iso_write_a: assert property (iso_wr |=> ISO_OUT[7:0] == $past(IO_REQ.wdata))
        else $error("iso out not written");
    // a change needs a recent register write or a pin change two edges back
    irq_cause_a: assert property ($changed(IRQ_N) |-> $past(IO_REQ.wr) || $past(IO_REQ.wr, 2) ||
        $past(PLAIN_IN[1:0]) != $past(PLAIN_IN[1:0], 2) ||
        $past(PLAIN_IN[1:0], 2) != $past(PLAIN_IN[1:0], 3)) else $error("irq moved alone");
endmodule
bind idil_top idil_checker #(.DIO_WIDTH(DIO_WIDTH)) i_idil_checker (.CLK(CLK), .ARST_N(ARST_N),
    .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID), .PLAIN_IN(PLAIN_IN),
    .PLAIN_IN_ENABLE(PLAIN_IN_ENABLE), .PLAIN_OUT(PLAIN_OUT), .ISO_IN(ISO_IN),
    .ISO_OUT(ISO_OUT), .IRQ_N(IRQ_N));

// ### idil_host.sv
// host software model: byte i/o cycles and the interrupt service
// assumes requests taken on rising CLK, read answer one cycle later
module idil_host
    import idil_pkg::*;
(
    // clock and host port
    input wire logic CLK,
    output idil_io_req_t IO_REQ,
    input wire logic [7:0] IO_RDATA,
    input wire logic IO_RVALID
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] saved = 8'h00;
    logic [7:0] pol = 8'h00;
    initial IO_REQ = '{8'h00, 8'h00, 1'b0, 1'b0};
    task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        IO_REQ <= '{a, d, 1'b1, 1'b0};
        @(posedge CLK);
        // released lines flip so stale values cannot pass
        IO_REQ <= '{~a, ~d, 1'b0, 1'b0};
    endtask
    task automatic io_rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge CLK);
        IO_REQ <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge CLK);
        IO_REQ <= '{~a, 8'hff, 1'b0, 1'b0};
        #1;
        d = IO_RDATA;
        v = IO_RVALID;
    endtask
    task automatic service();
        logic [7:0] s;
        logic v;
        io_rd(IDIL_OFS_IRQ_SOURCE_STATUS, s, v);
        pol = pol ^ ((s ^ saved) & 8'h03);
        saved = s;
        io_wr(IDIL_OFS_IRQ_POLARITY_SELECT, pol);
    endtask
endmodule

// ### tb_idil_top.sv
// self-checking bench for the i/o and interrupt block
// assumes idil_pkg, idil_host and idil_checker compiled first
module tb_idil_top
    import idil_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    idil_io_req_t io_req;
    logic [7:0] io_rdata, rd;
    logic io_rvalid, plain_in_enable, irq_n, v;
    logic [15:0] plain_in = 16'h0000, iso_in = 16'h0000, plain_out, iso_out;
    int n_mismatch = 0;
    int checks_done = 0;
    always #2.5 CLK = ~CLK;
    idil_top #(.DIO_WIDTH(16)) i_idil_top (.CLK(CLK), .ARST_N(ARST_N), .IO_REQ(io_req),
        .IO_RDATA(io_rdata), .IO_RVALID(io_rvalid), .PLAIN_IN(plain_in),
        .PLAIN_IN_ENABLE(plain_in_enable), .PLAIN_OUT(plain_out), .ISO_IN(iso_in),
        .ISO_OUT(iso_out), .IRQ_N(irq_n));
    idil_host i_idil_host (.CLK(CLK), .IO_REQ(io_req), .IO_RDATA(io_rdata), .IO_RVALID(io_rvalid));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        i_idil_host.io_rd(a, rd, v);
        check(what, {v, rd}, {1'b1, exp});
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // channel is the polarity-adjusted source gated by enable
    function automatic logic irq_exp(input logic [1:0] en, input logic [1:0] p, input logic [1:0] s);
        return !(|(en & ~(p ^ s)));
    endfunction
    initial begin
        void'($urandom(55));
        repeat (16) @(posedge CLK);
        ARST_N <= 1'b1;
        plain_in <= 16'hfcfc;
        i_idil_host.io_wr(IDIL_OFS_ISO_OUT_LO, 8'h5a);
        rdchk("iso locked", IDIL_OFS_ISO_OUT_LO, 8'h00);
        rdchk("plain off", IDIL_OFS_PLAIN_IN_LO, 8'h00);
        check("irq idle", irq_n, 1'b1);
        i_idil_host.io_wr(IDIL_OFS_BOARD_RESET, 8'h01);
        rdchk("run back", IDIL_OFS_BOARD_RESET, 8'h01);
        for (int i = 0; i < 8; i++) begin
            logic [15:0] r;
            r = (i == 0) ? 16'hffff : 16'($urandom());
            @(posedge CLK);
            iso_in <= r;
            plain_in <= r;
            i_idil_host.io_wr(IDIL_OFS_ISO_OUT_HI, r[7:0]);
            i_idil_host.io_wr(IDIL_OFS_PLAIN_OUT_LO, r[15:8]);
            #1 check("iso pin", iso_out[15:8], r[7:0]);
            check("plain pin", plain_out[7:0], r[15:8]);
            rdchk("iso back", IDIL_OFS_ISO_OUT_HI, r[7:0]);
            rdchk("iso in", IDIL_OFS_ISO_IN_LO, ~r[7:0]);
            rdchk("plain in", IDIL_OFS_PLAIN_IN_HI, r[15:8]);
            rdchk("plain in lo", IDIL_OFS_PLAIN_IN_LO, r[7:0]);
            rdchk("iso in hi", IDIL_OFS_ISO_IN_HI, ~r[15:8]);
            rdchk("status", IDIL_OFS_IRQ_SOURCE_STATUS, {6'h00, r[1:0]});
        end
        rdchk("unmapped", 8'h3f, IDIL_READ_UNMAPPED);
        for (int k = 0; k < 64; k++) begin
            @(posedge CLK);
            plain_in <= 16'(k[1:0]);
            i_idil_host.io_wr(IDIL_OFS_IRQ_ENABLE, {6'h00, k[5:4]});
            i_idil_host.io_wr(IDIL_OFS_IRQ_POLARITY_SELECT, {6'h00, k[3:2]});
            repeat (2) @(posedge CLK);
            #1 check("irq level", irq_n, irq_exp(k[5:4], k[3:2], k[1:0]));
        end
        rdchk("enable back", IDIL_OFS_IRQ_ENABLE, 8'h03);
        rdchk("polarity back", IDIL_OFS_IRQ_POLARITY_SELECT, 8'h03);
        @(posedge CLK);
        plain_in <= 16'h0000;
        i_idil_host.pol = 8'h03;
        i_idil_host.saved = 8'h00;
        i_idil_host.io_wr(IDIL_OFS_IRQ_POLARITY_SELECT, 8'h03);
        for (int j = 0; j < 2; j++) begin
            @(posedge CLK);
            plain_in <= (j == 0) ? 16'h0003 : 16'h0000;
            repeat (3) @(posedge CLK);
            #1 check("irq both", irq_n, 1'b0);
            i_idil_host.service();
            repeat (2) @(posedge CLK);
            #1 check("irq served", irq_n, 1'b1);
        end
        i_idil_host.io_wr(IDIL_OFS_BOARD_RESET, 8'h00);
        repeat (2) @(posedge CLK);
        #1 check("run off outs", plain_out | iso_out, 16'h0000);
        check("run off in", plain_in_enable, 1'b0);
        // second power-up in mid-run must clear live outputs
        i_idil_host.io_wr(IDIL_OFS_BOARD_RESET, 8'h01);
        i_idil_host.io_wr(IDIL_OFS_PLAIN_OUT_LO, 8'hff);
        @(posedge CLK);
        ARST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        ARST_N <= 1'b1;
        #1 check("reset outs", plain_out | iso_out, 16'h0000);
        check("reset irq", irq_n, 1'b1);
        rdchk("reset run", IDIL_OFS_BOARD_RESET, 8'h00);
        tally_and_finish();
    end
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
